// *** hw/l2em_defs.svh ***
// constants for the error response and event monitor block
`ifndef L2EM_DEFS_SVH
`define L2EM_DEFS_SVH

// ****************************************
// register map
// ****************************************
`define L2EM_OFS_AUX_CTRL    8'h00
`define L2EM_OFS_PF_CTRL     8'h04
`define L2EM_OFS_DBG_CTRL    8'h08
`define L2EM_OFS_IRQ_STAT    8'h0c
`define L2EM_BIT_EVBUS_EN    20
`define L2EM_BIT_PF_DROP     24
`define L2EM_BIT_SEC_DBG     2
`define L2EM_BIT_IRQ_DEC     0
`define L2EM_BIT_IRQ_SLV     1

// ****************************************
// responses
// ****************************************
`define L2EM_RESP_OKAY       2'h0
`define L2EM_RESP_SLVERR     2'h2
`define L2EM_RESP_DECERR     2'h3

// ****************************************
// event bus bit positions
// ****************************************
`define L2EM_NUM_EV          18
`define L2EM_EV_LINE_EVICTION 0
`define L2EM_EV_DATA_READ_HIT 1
`define L2EM_EV_DATA_READ_LOOKUP 2
`define L2EM_EV_DATA_WRITE_HIT 3
`define L2EM_EV_DATA_WRITE_LOOKUP 4
`define L2EM_EV_WRITETHROUGH_LOOKUP 5
`define L2EM_EV_HINT_ALLOC   6
`define L2EM_EV_HINT_HIT     7
`define L2EM_EV_HINT_RX_PORT0 8
`define L2EM_EV_HINT_RX_PORT1 9
`define L2EM_EV_INTERNAL_PREFETCH_ALLOC 10
`define L2EM_EV_INSTR_READ_HIT 11
`define L2EM_EV_INSTR_READ_LOOKUP 12
`define L2EM_EV_SPEC_READ_CONFIRM_PORT0 13
`define L2EM_EV_SPEC_READ_CONFIRM_PORT1 14
`define L2EM_EV_SPEC_READ_RX_PORT0 15
`define L2EM_EV_SPEC_READ_RX_PORT1 16
`define L2EM_EV_WRITE_ALLOC  17

`endif

// *** hw/l2em_pkg.sv ***
// types shared by the error response and event monitor block
package l2em_pkg;
  typedef enum logic [2:0] {
    WK_NONBUF, WK_EVICT, WK_SBDRAIN, WK_WALLOC, WK_WTHRU
  } wr_kind_type;
  typedef enum logic [1:0] {
    RK_NONCACHE, RK_RAFILL, RK_PREFETCH
  } rd_kind_type;
endpackage

// *** hw/l2em_top.sv ***
// error response routing, prefetch dropping and event bus
`timescale 1ns/1ps
`include "l2em_defs.svh"
module l2em_top #(
  parameter int IDW  = 4,
  parameter int DW   = 64,
  parameter int NOTH = 7
) (
  // clock and reset
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  // ahb-lite register slave
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic                           hreadyout,
  output logic                           hresp,
  output logic [31:0]                    hrdata,
  // master port slot arbitration
  input  wire logic                      pf_req,
  input  wire logic [IDW-1:0]            pf_id,
  input  wire logic                      npf_req,
  input  wire logic                      slot_free,
  output logic                           pf_grant,
  output logic                           npf_grant,
  // memory side read return
  input  wire logic                      m_rvalid,
  input  wire logic [IDW-1:0]            m_rid,
  input  wire logic [DW-1:0]             m_rdata,
  input  wire logic [1:0]                m_rresp,
  input  wire logic                      m_rlast,
  input  wire l2em_pkg::rd_kind_type     m_rkind,
  // memory side write response
  input  wire logic                      m_bvalid,
  input  wire logic [IDW-1:0]            m_bid,
  input  wire logic [1:0]                m_bresp,
  input  wire l2em_pkg::wr_kind_type     m_bkind,
  // bufferable write accepted on slave port
  input  wire logic                      s_buf_wr_accept,
  input  wire logic [IDW-1:0]            s_buf_wr_id,
  // slave port responses
  output logic                           s_rvalid,
  output logic [IDW-1:0]                 s_rid,
  output logic [DW-1:0]                  s_rdata,
  output logic [1:0]                     s_rresp,
  output logic                           s_rlast,
  output logic                           s_bvalid,
  output logic [IDW-1:0]                 s_bid,
  output logic [1:0]                     s_bresp,
  // cache allocation of a finished line
  output logic                           line_commit,
  // error sources and interrupts
  input  wire logic                      ram_slverr,
  input  wire logic                      ram_decerr,
  input  wire logic [NOTH-1:0]           other_irq,
  output logic                           slave_error_irq,
  output logic                           decode_error_irq,
  output logic                           combined_cache_irq,
  // event monitoring
  input  wire logic                      secure_noninvasive_debug_enable,
  input  wire logic [`L2EM_NUM_EV-1:0]   ev_raw,
  input  wire logic [`L2EM_NUM_EV-1:0]   ev_secure,
  output logic [`L2EM_NUM_EV-1:0]        event_bus
);
  localparam int NID = 2 ** IDW;

  logic                     wr_pend_reg;
  logic                     rd_pend_reg;
  logic [7:0]               addr_reg;
  logic                     evbus_en_reg;
  logic                     pf_drop_reg;
  logic                     sec_meta_reg;
  logic                     sec_sync_reg;
  logic                     slv_reg;
  logic                     dec_reg;
  logic                     slv_next;
  logic                     dec_next;
  logic                     comb_reg;
  logic                     conflict;
  logic                     pf_dropped;
  logic [NID-1:0]           drop_mark_reg;
  logic                     discard;
  logic [1:0]               fill_err_reg;
  logic [1:0]               worst;
  logic                     fwd;
  logic                     pend_reg;
  logic [IDW-1:0]           pend_id_reg;
  logic                     s_rvalid_reg;
  logic [IDW-1:0]           s_rid_reg;
  logic [DW-1:0]            s_rdata_reg;
  logic [1:0]               s_rresp_reg;
  logic                     s_rlast_reg;
  logic                     s_bvalid_reg;
  logic [IDW-1:0]           s_bid_reg;
  logic [1:0]               s_bresp_reg;
  logic                     commit_reg;
  logic                     w_err;
  logic                     r_err;
  logic                     w1c;
  logic [`L2EM_NUM_EV-1:0]  ev_reg;
  logic [`L2EM_NUM_EV-1:0]  ev_pass;

  // ****************************************
  // ahb-lite slave, zero wait states
  // ****************************************
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end else if (hready) begin
      wr_pend_reg <= hsel & htrans[1] & hwrite;
      rd_pend_reg <= hsel & htrans[1] & ~hwrite;
      addr_reg    <= haddr[7:0];
    end
  end

  // read mux in the data phase so a write just before is seen
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_pend_reg) begin
      case (addr_reg)
        `L2EM_OFS_AUX_CTRL: hrdata[`L2EM_BIT_EVBUS_EN] = evbus_en_reg;
        `L2EM_OFS_PF_CTRL:  hrdata[`L2EM_BIT_PF_DROP] = pf_drop_reg;
        `L2EM_OFS_DBG_CTRL: hrdata[`L2EM_BIT_SEC_DBG] = sec_sync_reg;
        `L2EM_OFS_IRQ_STAT: begin
          hrdata[`L2EM_BIT_IRQ_DEC] = dec_reg;
          hrdata[`L2EM_BIT_IRQ_SLV] = slv_reg;
        end
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evbus_en_reg <= 1'b0;
      pf_drop_reg  <= 1'b0;
    end else if (wr_pend_reg) begin
      if (addr_reg == `L2EM_OFS_AUX_CTRL) begin
        evbus_en_reg <= hwdata[`L2EM_BIT_EVBUS_EN];
      end
      if (addr_reg == `L2EM_OFS_PF_CTRL) begin
        pf_drop_reg <= hwdata[`L2EM_BIT_PF_DROP];
      end
    end
  end

  // ****************************************
  // prefetch dropping
  // ****************************************
  assign conflict   = pf_req & npf_req & slot_free;
  assign npf_grant  = npf_req & slot_free;
  assign pf_grant   = pf_req & slot_free & ~(pf_drop_reg & npf_req);
  assign pf_dropped = conflict & pf_drop_reg;
  assign discard    = m_rvalid & (m_rkind == l2em_pkg::RK_PREFETCH) & drop_mark_reg[m_rid];

  // a dropped id stays marked until its late data drains; set beats clear
  genvar gi;
  generate
    for (gi = 0; gi < NID; gi++) begin : g_mark
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          drop_mark_reg[gi] <= 1'b0;
        end else if (pf_dropped && pf_id == IDW'(gi)) begin
          drop_mark_reg[gi] <= 1'b1;
        end else if (discard && m_rlast && m_rid == IDW'(gi)) begin
          drop_mark_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // read return path
  // ****************************************
  // one fill in flight at a time: worst response seen so far in it
  assign worst = (m_rresp > fill_err_reg) ? m_rresp : fill_err_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fill_err_reg <= `L2EM_RESP_OKAY;
    end else if (m_rvalid && m_rkind != l2em_pkg::RK_NONCACHE && !discard) begin
      fill_err_reg <= m_rlast ? `L2EM_RESP_OKAY : worst;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_rvalid_reg <= 1'b0;
      s_rid_reg    <= '0;
      s_rdata_reg  <= '0;
      s_rresp_reg  <= `L2EM_RESP_OKAY;
      s_rlast_reg  <= 1'b0;
    end else begin
      s_rvalid_reg <= m_rvalid & (m_rkind != l2em_pkg::RK_PREFETCH);
      if (m_rvalid) begin
        s_rid_reg   <= m_rid;
        s_rdata_reg <= m_rdata;
        s_rlast_reg <= m_rlast;
        // precise for non-cacheable, carried through the whole fill
        s_rresp_reg <= (m_rkind == l2em_pkg::RK_RAFILL) ? worst : m_rresp;
      end
    end
  end

  // the line is written and tagged only once it ended clean
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      commit_reg <= 1'b0;
    end else begin
      commit_reg <= m_rvalid & m_rlast & ~discard & (m_rkind != l2em_pkg::RK_NONCACHE)
                    & (worst == `L2EM_RESP_OKAY);
    end
  end

  // ****************************************
  // write response path
  // ****************************************
  assign fwd = m_bvalid & (m_bkind == l2em_pkg::WK_NONBUF);

  // forwarded responses win; one local OKAY can wait behind them
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_bvalid_reg <= 1'b0;
      s_bid_reg    <= '0;
      s_bresp_reg  <= `L2EM_RESP_OKAY;
      pend_reg     <= 1'b0;
      pend_id_reg  <= '0;
    end else if (fwd) begin
      s_bvalid_reg <= 1'b1;
      s_bid_reg    <= m_bid;
      s_bresp_reg  <= m_bresp;
      if (s_buf_wr_accept) begin
        pend_reg    <= 1'b1;
        pend_id_reg <= s_buf_wr_id;
      end
    end else if (pend_reg || s_buf_wr_accept) begin
      s_bvalid_reg <= 1'b1;
      s_bid_reg    <= pend_reg ? pend_id_reg : s_buf_wr_id;
      s_bresp_reg  <= `L2EM_RESP_OKAY;
      pend_reg     <= pend_reg & s_buf_wr_accept;
      pend_id_reg  <= s_buf_wr_id;
    end else begin
      s_bvalid_reg <= 1'b0;
    end
  end

  // ****************************************
  // error interrupts
  // ****************************************
  // decode errors include security mismatches answered by memory
  assign w_err = m_bvalid & ~fwd & m_bresp[1];
  assign r_err = m_rvalid & (m_rkind != l2em_pkg::RK_NONCACHE) & ~discard & m_rresp[1];
  assign w1c   = wr_pend_reg & (addr_reg == `L2EM_OFS_IRQ_STAT);

  // set beats clear in the same cycle
  always_comb begin
    slv_next = slv_reg & ~(w1c & hwdata[`L2EM_BIT_IRQ_SLV]);
    dec_next = dec_reg & ~(w1c & hwdata[`L2EM_BIT_IRQ_DEC]);
    if ((w_err && m_bresp == `L2EM_RESP_SLVERR) || (r_err && m_rresp == `L2EM_RESP_SLVERR)
        || ram_slverr) begin
      slv_next = 1'b1;
    end
    if ((w_err && m_bresp == `L2EM_RESP_DECERR) || (r_err && m_rresp == `L2EM_RESP_DECERR)
        || ram_decerr) begin
      dec_next = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slv_reg  <= 1'b0;
      dec_reg  <= 1'b0;
      comb_reg <= 1'b0;
    end else begin
      slv_reg  <= slv_next;
      dec_reg  <= dec_next;
      comb_reg <= slv_next | dec_next | (|other_irq);
    end
  end

  // ****************************************
  // secure debug enable and event bus
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_meta_reg <= 1'b0;
      sec_sync_reg <= 1'b0;
    end else begin
      sec_meta_reg <= secure_noninvasive_debug_enable;
      sec_sync_reg <= sec_meta_reg;
    end
  end

  // bit order of the bus follows the event index constants
  generate
    for (gi = 0; gi < `L2EM_NUM_EV; gi++) begin : g_ev
      assign ev_pass[gi] = evbus_en_reg & ev_raw[gi] & (~ev_secure[gi] | sec_sync_reg);
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ev_reg[gi] <= 1'b0;
        end else begin
          ev_reg[gi] <= ev_pass[gi];
        end
      end
    end
  endgenerate

  assign s_rvalid           = s_rvalid_reg;
  assign s_rid              = s_rid_reg;
  assign s_rdata            = s_rdata_reg;
  assign s_rresp            = s_rresp_reg;
  assign s_rlast            = s_rlast_reg;
  assign s_bvalid           = s_bvalid_reg;
  assign s_bid              = s_bid_reg;
  assign s_bresp            = s_bresp_reg;
  assign line_commit        = commit_reg;
  assign slave_error_irq    = slv_reg;
  assign decode_error_irq   = dec_reg;
  assign combined_cache_irq = comb_reg;
  assign event_bus          = ev_reg;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_PF_DROP: assert property (pf_drop_reg && conflict |-> !pf_grant && npf_grant)
    else $error("prefetch not dropped on conflict");
  AST_DISCARD: assert property (discard && m_rlast |=> !line_commit && !s_rvalid)
    else $error("dropped prefetch data used");
  AST_NB_FWD: assert property (fwd |=> s_bvalid && s_bresp == $past(m_bresp))
    else $error("non-bufferable response not forwarded");
  AST_BUF_OKAY: assert property (s_buf_wr_accept && !fwd && !pend_reg
    |=> s_bvalid && s_bresp == `L2EM_RESP_OKAY && s_bid == $past(s_buf_wr_id))
    else $error("bufferable write not answered okay");
  AST_RBEAT: assert property (m_rvalid && m_rkind != l2em_pkg::RK_PREFETCH
    |=> s_rvalid && s_rlast == $past(m_rlast))
    else $error("read beat lost");
  AST_RA_ERR: assert property (m_rvalid && m_rkind == l2em_pkg::RK_RAFILL
    && m_rresp == `L2EM_RESP_SLVERR && m_rlast |=> !line_commit && slave_error_irq)
    else $error("erroring fill allocated or no irq");
  AST_EVICT_IRQ: assert property (m_bvalid && m_bkind == l2em_pkg::WK_EVICT
    && m_bresp == `L2EM_RESP_DECERR |=> decode_error_irq)
    else $error("eviction error not on irq");
  AST_NC_PRECISE: assert property (m_rvalid && m_rkind == l2em_pkg::RK_NONCACHE
    |=> s_rresp == $past(m_rresp) && s_rid == $past(m_rid))
    else $error("non-cacheable response altered");
  AST_FILL_ERR: assert property (m_rvalid && m_rkind == l2em_pkg::RK_RAFILL && m_rresp[1]
    && !m_rlast ##1 m_rvalid && m_rkind == l2em_pkg::RK_RAFILL |=> s_rresp[1])
    else $error("fill error not carried on");
  AST_EV_GATE: assert property (!(|(event_bus & ~$past(ev_raw))))
    else $error("event without occurrence");
  AST_EV_SEC: assert property (|(event_bus & $past(ev_secure)) |-> $past(sec_sync_reg))
    else $error("secure event leaked");
  AST_EV_EN: assert property (!$past(evbus_en_reg) |-> event_bus == '0)
    else $error("event bus driven while off");
  AST_SYNC: assert property ($stable(secure_noninvasive_debug_enable) [*3]
    |-> sec_sync_reg == secure_noninvasive_debug_enable)
    else $error("debug enable sync wrong");
  AST_COMB: assert property (combined_cache_irq
    == (slave_error_irq | decode_error_irq | $past(|other_irq)))
    else $error("combined irq mismatch");

  COV_DROP: cover property (pf_dropped ##[1:50] discard && m_rlast);
  COV_RA_ERR: cover property (r_err && m_rkind == l2em_pkg::RK_RAFILL ##1 slave_error_irq);
  COV_BUF_PEND: cover property (fwd && s_buf_wr_accept ##1 s_bvalid ##1 s_bvalid);
  COV_SEC_EV: cover property (sec_sync_reg && |(event_bus & $past(ev_secure)));
endmodule

// *** test/l2em_mem_model.sv ***
// far-side memory model returning read beats and write responses
`timescale 1ns/1ps
`include "l2em_defs.svh"
module l2em_mem_model #(
  parameter int IDW = 4,
  parameter int DW  = 64
) (
  // clock
  input  wire logic             hclk,
  // memory side
  output logic                  m_rvalid,
  output logic [IDW-1:0]        m_rid,
  output logic [DW-1:0]         m_rdata,
  output logic [1:0]            m_rresp,
  output logic                  m_rlast,
  output l2em_pkg::rd_kind_type m_rkind,
  output logic                  m_bvalid,
  output logic [IDW-1:0]        m_bid,
  output logic [1:0]            m_bresp,
  output l2em_pkg::wr_kind_type m_bkind
);
  initial begin
    {m_rvalid, m_rid, m_rdata, m_rresp, m_rlast, m_bvalid, m_bid, m_bresp} = '0;
    m_rkind = l2em_pkg::RK_NONCACHE;
    m_bkind = l2em_pkg::WK_NONBUF;
  end
  // security mismatch always answered with decode error
  function automatic logic [1:0] rsp(input logic sec_bad, input logic [1:0] r);
    return sec_bad ? `L2EM_RESP_DECERR : r;
  endfunction
  // one burst of n beats, slave error on beat bad
  task automatic rd(input l2em_pkg::rd_kind_type k, input logic [IDW-1:0] id, input int n,
                    input int bad, input logic sec_bad);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk);
      m_rvalid <= 1'b1;
      m_rid <= id;
      m_rdata <= DW'(i + 1);
      m_rresp <= rsp(sec_bad, (i == bad) ? `L2EM_RESP_SLVERR : `L2EM_RESP_OKAY);
      m_rlast <= (i == n - 1);
      m_rkind <= k;
    end
    @(posedge hclk);
    // released lines flip so stale data never looks valid
    m_rvalid <= 1'b0;
    m_rdata <= ~m_rdata;
    m_rresp <= ~m_rresp;
    m_rlast <= 1'b0;
  endtask
  task automatic wr(input l2em_pkg::wr_kind_type k, input logic [IDW-1:0] id,
                    input logic [1:0] r, input logic sec_bad);
    @(posedge hclk);
    m_bvalid <= 1'b1;
    m_bid <= id;
    m_bresp <= rsp(sec_bad, r);
    m_bkind <= k;
    @(posedge hclk);
    m_bvalid <= 1'b0;
    m_bid <= ~id;
    m_bresp <= ~m_bresp;
  endtask
endmodule

// *** test/tb.sv ***
// self-checking bench of the error response and event monitor block
`timescale 1ns/1ps
`include "l2em_defs.svh"
module tb;
  localparam int NEV = `L2EM_NUM_EV;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, v;
  logic [1:0] htrans, m_rresp, m_bresp, s_rresp, s_bresp, rresp_l, bresp_l;
  logic [2:0] hsize;
  logic pf_req, npf_req, slot_free, pf_grant, npf_grant;
  logic [3:0] pf_id, m_rid, m_bid, s_buf_wr_id, s_rid, s_bid, bid_l;
  logic m_rvalid, m_rlast, m_bvalid, s_buf_wr_accept, s_rvalid, s_rlast, s_bvalid;
  logic line_commit, ram_slverr, ram_decerr, slave_error_irq, decode_error_irq;
  logic combined_cache_irq, secure_noninvasive_debug_enable;
  logic [63:0] m_rdata, s_rdata, rdata_l;
  l2em_pkg::rd_kind_type m_rkind;
  l2em_pkg::wr_kind_type m_bkind;
  logic [6:0] other_irq;
  logic [NEV-1:0] ev_raw, ev_secure, event_bus, ev_l;
  int mismatches, cmp_count, rbeats, commits, bcnt, evcnt;
  assign hready = hreadyout;
  l2em_top #(.IDW(4), .DW(64), .NOTH(7)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .pf_req, .pf_id, .npf_req, .slot_free, .pf_grant, .npf_grant,
    .m_rvalid, .m_rid, .m_rdata, .m_rresp, .m_rlast, .m_rkind, .m_bvalid, .m_bid, .m_bresp,
    .m_bkind, .s_buf_wr_accept, .s_buf_wr_id, .s_rvalid, .s_rid, .s_rdata, .s_rresp,
    .s_rlast, .s_bvalid, .s_bid, .s_bresp, .line_commit, .ram_slverr, .ram_decerr,
    .other_irq, .slave_error_irq, .decode_error_irq, .combined_cache_irq,
    .secure_noninvasive_debug_enable, .ev_raw, .ev_secure, .event_bus);
  l2em_mem_model #(.IDW(4), .DW(64)) mem (.hclk, .m_rvalid, .m_rid, .m_rdata, .m_rresp,
    .m_rlast, .m_rkind, .m_bvalid, .m_bid, .m_bresp, .m_bkind);
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  // ****************************************
  // monitors, sampled before the edge updates
  // ****************************************
  always @(posedge hclk) begin
    if (s_rvalid === 1'b1) begin
      rbeats++;
      rresp_l <= s_rresp;
      rdata_l <= s_rdata;
    end
    if (line_commit === 1'b1) commits++;
    if (s_bvalid === 1'b1) begin
      bcnt++;
      bresp_l <= s_bresp;
      bid_l <= s_bid;
    end
    if (event_bus !== '0) begin
      evcnt++;
      ev_l <= event_bus;
    end
  end
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask
  task automatic clr();
    {rbeats, commits, bcnt, evcnt} = '0;
  endtask
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    v = hrdata;
  endtask
  task automatic pulse(input logic [NEV-1:0] m, input logic [NEV-1:0] s);
    @(posedge hclk);
    ev_raw <= m;
    ev_secure <= s;
    @(posedge hclk);
    ev_raw <= '0;
    ev_secure <= '0;
    step(3);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_drop();
    @(posedge hclk);
    {pf_req, npf_req, slot_free} <= 3'h7;
    pf_id <= 4'h5;
    step(0);
    chk("pf_grant_off", pf_grant, 1);
    ahb(1, `L2EM_OFS_PF_CTRL, 32'h1 << 24);
    step(0);
    chk("pf_grant_on", {pf_grant, npf_grant}, 2'h1);
    // hold the conflict one more edge so the drop is taken with its id
    @(posedge hclk);
    {pf_req, npf_req, slot_free} <= 3'h0;
    clr();
    mem.rd(l2em_pkg::RK_PREFETCH, 4'h5, 4, -1, 1'b0);
    step(3);
    chk("drop_commit", commits + rbeats, 0);
    mem.rd(l2em_pkg::RK_PREFETCH, 4'h6, 4, -1, 1'b0);
    step(3);
    chk("pf_commit", commits, 1);
    ahb(1, `L2EM_OFS_PF_CTRL, 32'h0);
  endtask
  task automatic t_wr();
    clr();
    mem.wr(l2em_pkg::WK_NONBUF, 4'h3, `L2EM_RESP_SLVERR, 1'b0);
    step(2);
    chk("fwd_b", {bid_l, bresp_l}, {4'h3, `L2EM_RESP_SLVERR});
    mem.wr(l2em_pkg::WK_NONBUF, 4'h4, `L2EM_RESP_OKAY, 1'b1);
    step(2);
    chk("sec_b", bresp_l, `L2EM_RESP_DECERR);
    fork
      mem.wr(l2em_pkg::WK_NONBUF, 4'h1, `L2EM_RESP_SLVERR, 1'b0);
      begin
        @(posedge hclk);
        s_buf_wr_accept <= 1'b1;
        s_buf_wr_id <= 4'h2;
        @(posedge hclk);
        s_buf_wr_accept <= 1'b0;
      end
    join
    step(3);
    chk("buf_b", {bcnt[3:0], bid_l, bresp_l}, {4'h4, 4'h2, `L2EM_RESP_OKAY});
    chk("fwd_noirq", slave_error_irq, 0);
  endtask
  task automatic t_imp();
    l2em_pkg::wr_kind_type k;
    k = l2em_pkg::WK_EVICT;
    for (int i = 0; i < 4; i++) begin
      clr();
      mem.wr(k, 4'h1, `L2EM_RESP_SLVERR, i == 3);
      step(3);
      chk("imp_b", bcnt, 0);
      chk("imp_irq", {decode_error_irq, slave_error_irq}, (i == 3) ? 2'h2 : 2'h1);
      chk("imp_comb", combined_cache_irq, 1);
      ahb(0, `L2EM_OFS_IRQ_STAT, 32'h0);
      chk("imp_stat", v, (i == 3) ? 32'h1 : 32'h2);
      ahb(1, `L2EM_OFS_IRQ_STAT, 32'h3);
      step(1);
      chk("imp_clr", {combined_cache_irq, slave_error_irq, decode_error_irq}, 0);
      k = k.next();
    end
  endtask
  task automatic t_rd();
    clr();
    mem.rd(l2em_pkg::RK_NONCACHE, 4'h2, 1, 0, 1'b0);
    step(3);
    chk("nc_r", {rbeats[3:0], rresp_l, slave_error_irq}, {4'h1, `L2EM_RESP_SLVERR, 1'b0});
    chk("nc_data", rdata_l[31:0], 32'h1);
    clr();
    mem.rd(l2em_pkg::RK_RAFILL, 4'h3, 4, 1, 1'b0);
    step(3);
    chk("ra_err", {rbeats[3:0], rresp_l}, {4'h4, `L2EM_RESP_SLVERR});
    chk("ra_data", rdata_l[31:0], 32'h4);
    chk("ra_nocommit", {commits[0], slave_error_irq}, 2'h1);
    ahb(1, `L2EM_OFS_IRQ_STAT, 32'h3);
    clr();
    mem.rd(l2em_pkg::RK_RAFILL, 4'h3, 4, -1, 1'b0);
    step(3);
    chk("ra_ok", {commits[3:0], rresp_l}, {4'h1, `L2EM_RESP_OKAY});
  endtask
  task automatic t_misc();
    @(posedge hclk);
    {ram_slverr, ram_decerr} <= 2'h3;
    @(posedge hclk);
    {ram_slverr, ram_decerr} <= 2'h0;
    step(3);
    chk("ram_irq", {slave_error_irq, decode_error_irq}, 2'h3);
    ahb(1, `L2EM_OFS_IRQ_STAT, 32'h3);
    other_irq <= 7'h40;
    step(2);
    chk("oth_on", combined_cache_irq, 1);
    @(posedge hclk);
    other_irq <= 7'h0;
    step(2);
    chk("oth_off", combined_cache_irq, 0);
  endtask
  task automatic t_ev();
    clr();
    pulse('1, '0);
    chk("ev_off", evcnt, 0);
    ahb(1, `L2EM_OFS_AUX_CTRL, 32'h1 << 20);
    ahb(0, `L2EM_OFS_AUX_CTRL, 32'h0);
    chk("aux_rd", v, 32'h1 << 20);
    ahb(0, 8'h40, 32'h0);
    chk("unmapped", v, 0);
    chk("hresp", hresp, 0);
    for (int i = 0; i < NEV; i++) begin
      clr();
      pulse(NEV'(1) << i, '0);
      chk("ev_one", {evcnt[7:0], ev_l}, {8'h1, NEV'(1) << i});
    end
    clr();
    pulse('1, '1);
    chk("ev_sec_lo", evcnt, 0);
    @(posedge hclk);
    secure_noninvasive_debug_enable <= 1'b1;
    // settle stands in for the cache sync
    step(4);
    ahb(0, `L2EM_OFS_DBG_CTRL, 32'h0);
    chk("dbg_bit", v[`L2EM_BIT_SEC_DBG], 1);
    clr();
    pulse(18'h3, 18'h1);
    chk("ev_sec_hi", {evcnt[7:0], ev_l}, {8'h1, 18'h3});
  endtask
  initial begin
    {hsel, hwrite, pf_req, npf_req, slot_free, s_buf_wr_accept, ram_slverr, ram_decerr} = '0;
    {haddr, hwdata, htrans, pf_id, s_buf_wr_id, other_irq, ev_raw, ev_secure} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    secure_noninvasive_debug_enable = 1'b0;
    {mismatches, cmp_count} = '0;
    clr();
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_drop();
    t_wr();
    t_imp();
    t_rd();
    t_misc();
    t_ev();
    end_sim();
  end
  initial begin
    #400000;
    mismatches++;
    end_sim();
  end
endmodule
